/* core/cms_pkg.sv */
// package for the command mode and sleep timing block
// assumes a 250 MHz aclk; all timers derive from a 1 ms tick
`default_nettype none
package cms_pkg;
    // clock and tick derivation
    localparam int CLK_MHZ        = 250;
    localparam int TICK_MS_NS     = 1000000;
    localparam int CLK_PERIOD_NS  = 4;
    localparam int TICK_CYCLES    = TICK_MS_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_10MS = 10;
    localparam int TICKS_PER_100MS = 100;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_CMD_TO    = 8'h04;
    localparam logic [7:0] OFS_GUARD     = 8'h08;
    localparam logic [7:0] OFS_ESC_CHAR  = 8'h0C;
    localparam logic [7:0] OFS_SLEEP_SEL = 8'h10;
    localparam logic [7:0] OFS_SLEEP_PER = 8'h14;
    localparam logic [7:0] OFS_SLEEP_OPT = 8'h18;
    localparam logic [7:0] OFS_HOST_WAKE = 8'h1C;
    localparam logic [7:0] OFS_WAKE_WIN  = 8'h20;
    localparam logic [7:0] OFS_ASSOC_TO  = 8'h24;
    localparam logic [7:0] OFS_STATUS    = 8'h28;
    localparam logic [7:0] OFS_LINK_MARG = 8'h2C;
    localparam logic [7:0] OFS_SUPPLY_MV = 8'h30;
    localparam logic [7:0] OFS_CFG_CODE  = 8'h34;
    // control bits
    localparam int CTRL_APPLY_BIT = 0;
    localparam int CTRL_EXIT_BIT  = 1;
    // reset values
    localparam logic [31:0] RST_CMD_TO    = 32'h0000_0064;
    localparam logic [31:0] RST_GUARD     = 32'h0000_03E8;
    localparam logic [31:0] RST_ESC_CHAR  = 32'h0000_002B;
    localparam logic [31:0] RST_SLEEP_SEL = 32'h0000_0000;
    localparam logic [31:0] RST_SLEEP_PER = 32'h0000_00C8;
    localparam logic [31:0] RST_SLEEP_OPT = 32'h0000_0100;
    localparam logic [31:0] RST_HOST_WAKE = 32'h0000_0000;
    localparam logic [31:0] RST_WAKE_WIN  = 32'h0000_07D0;
    localparam logic [31:0] RST_ASSOC_TO  = 32'h0000_2710;
    // sleep option bits
    localparam int OPT_KEEP_ASSOC_BIT = 6;
    localparam int OPT_NO_REFRESH_BIT = 8;
    localparam logic [31:0] OPT_MASK  = 32'h0000_01FF;
    // sleep select codes
    localparam logic [2:0] SEL_NONE       = 3'h0;
    localparam logic [2:0] SEL_PIN        = 3'h1;
    localparam logic [2:0] SEL_CYCLIC     = 3'h4;
    localparam logic [2:0] SEL_CYCLIC_PIN = 3'h5;
    localparam int ESC_COUNT = 3;
    // power states, one-hot
    typedef enum logic [3:0] {
        PWR_AWAKE  = 4'b0001,
        PWR_ASSOC  = 4'b0010,
        PWR_DRAIN  = 4'b0100,
        PWR_SLEEP  = 4'b1000
    } cms_pwr_t;
endpackage : cms_pkg
`default_nettype wire

/* core/cms_top.sv */
// command mode entry/exit and sleep/wake timing, with AXI4-Lite registers
// assumes pin inputs are asynchronous; rx_valid is a same-clock one-cycle strobe, not synchronised
// Summary of operation
// - leave command mode after inactivity timeout
// - exit command leaves mode and applies settings
// - escape needs guard silence before and after
// - three copies of programmable escape character
// - sleep behaviour chosen from mode code
// - cyclic sleep lasts programmed period
// - option bit keeps association while asleep
// - option bit blocks wake timer restarts
// - host-wake delay gates serial output
// - received character stops host-wake delay
// - stay awake for wake window, refreshed by received characters
// - finish pending transfers before cyclic sleeping
// - wait for association done or association timeout before deep sleep
// - report link margin read-only
// - report supply millivolts read-only
// - report two-byte configuration code
// - written values queue until applied
`default_nettype none
module cms_top #(
    parameter int TICK_CYCLES = cms_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // serial side: received character strobe (same clock) and command events
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_char,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_exit,
    // external pins and status (asynchronous)
    input  wire logic        sleep_pin,
    input  wire logic        assoc_done,
    input  wire logic        xfer_pending,
    input  wire logic [7:0]  link_margin,
    input  wire logic [15:0] supply_mv,
    // block outputs
    output logic             cmd_mode,
    output logic             asleep,
    output logic             keep_assoc,
    output logic             host_tx_allow
);
    // millisecond tick prescaler
    logic [31:0] pre_reg;
    logic        tick_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn) begin pre_reg <= '0; tick_reg <= 1'b0; end
        else begin
            tick_reg <= (pre_reg == 32'(TICK_CYCLES - 1));
            pre_reg  <= (pre_reg == 32'(TICK_CYCLES - 1)) ? '0 : pre_reg + 32'h1;
        end
    end

    // two-flop synchronisers for pins
    logic [2:0] s1_reg, s2_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn) begin s1_reg <= '0; s2_reg <= '0; end
        else begin
            s1_reg <= {xfer_pending, assoc_done, sleep_pin};
            s2_reg <= s1_reg;
        end
    end
    wire pin_sleep_s = s2_reg[0];
    wire assoc_s     = s2_reg[1];
    wire pend_s      = s2_reg[2];

    // queued and active settings
    logic [31:0] q_reg [9];
    logic [31:0] a_reg [9];
    logic        apply_pulse;
    logic        exit_pulse;
    localparam logic [31:0] RSTV [9] = '{cms_pkg::RST_CMD_TO, cms_pkg::RST_GUARD,
        cms_pkg::RST_ESC_CHAR, cms_pkg::RST_SLEEP_SEL, cms_pkg::RST_SLEEP_PER,
        cms_pkg::RST_SLEEP_OPT, cms_pkg::RST_HOST_WAKE, cms_pkg::RST_WAKE_WIN,
        cms_pkg::RST_ASSOC_TO};

    // axi write path: address and data accepted in either order
    logic        aw_got_reg, w_got_reg;
    logic [7:0]  aw_reg;
    logic [31:0] wd_reg;
    logic [3:0]  ws_reg;
    wire         wr_go  = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire  [3:0]  wr_idx = aw_reg[5:2];
    wire         wr_cfg = (aw_reg[7:6] == 2'b00) && aw_reg[5:2] >= 4'd1 && aw_reg[5:2] <= 4'd9;
    wire         wr_ctl = (aw_reg == cms_pkg::OFS_CTRL);
    wire         wr_ok  = wr_cfg || wr_ctl;
    wire  [31:0] wmask  = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
    assign apply_pulse = wr_go && wr_ctl && wd_reg[cms_pkg::CTRL_APPLY_BIT] && ws_reg[0];
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_reg <= 1'b0; w_got_reg <= 1'b0; aw_reg <= '0; wd_reg <= '0; ws_reg <= '0;
            s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'b00;
        end
        else
        begin
            s_axi_awready <= !aw_got_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_got_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin aw_got_reg <= 1'b1; aw_reg <= s_axi_awaddr; end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_reg <= 1'b1; wd_reg <= s_axi_wdata; ws_reg <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_got_reg <= 1'b0; w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1; s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            end
            else if (s_axi_bready) s_axi_bvalid <= 1'b0;
        end
    end

    // queued copies take writes; active copies change only on apply, exit command or inactivity timeout
    for (genvar i = 0; i < 9; i++)
    begin : g_cfg
        always_ff @(posedge aclk)
        begin
            if (!aresetn) begin q_reg[i] <= RSTV[i]; a_reg[i] <= RSTV[i]; end
            else
            begin
                if (wr_go && wr_cfg && wr_idx == 4'(i + 1))
                    q_reg[i] <= (q_reg[i] & ~wmask) | (wd_reg & wmask);
                if (apply_pulse || exit_pulse)
                    a_reg[i] <= q_reg[i];
            end
        end
    end
    wire [31:0] cmd_to    = a_reg[0];
    wire [31:0] guard     = a_reg[1];
    wire [7:0]  esc_char  = a_reg[2][7:0];
    wire [2:0]  sel       = a_reg[3][2:0];
    wire [31:0] sleep_per = a_reg[4];
    wire [31:0] opts      = a_reg[5] & cms_pkg::OPT_MASK;
    wire [15:0] wh_ms     = a_reg[6][15:0];
    wire [31:0] wake_win  = a_reg[7];
    wire [31:0] assoc_to  = a_reg[8];

    // escape detection: silence, three escapes, silence
    logic [31:0] quiet_reg;
    logic [1:0]  esc_n_reg;
    logic        armed_reg;
    wire         quiet_ok = (quiet_reg >= guard);
    wire         is_esc   = rx_valid && rx_char == esc_char;
    wire         enter    = !cmd_mode && esc_n_reg == 2'(cms_pkg::ESC_COUNT) && quiet_ok && tick_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn) begin quiet_reg <= '0; esc_n_reg <= '0; armed_reg <= 1'b0; end
        else if (rx_valid)
        begin
            quiet_reg <= '0;
            if (is_esc && esc_n_reg < 2'(cms_pkg::ESC_COUNT) && (armed_reg ? 1'b1 : quiet_ok))
            begin
                esc_n_reg <= esc_n_reg + 2'h1; armed_reg <= 1'b1;
            end
            else
            begin
                esc_n_reg <= '0; armed_reg <= 1'b0;
            end
        end
        else
        begin
            if (tick_reg && !quiet_ok) quiet_reg <= quiet_reg + 32'h1;
            if (enter) begin esc_n_reg <= '0; armed_reg <= 1'b0; end
        end
    end

    // command mode with inactivity timeout in 100 ms ticks
    logic [31:0] idle_ms_reg;
    wire         idle_out = (idle_ms_reg >= cmd_to * cms_pkg::TICKS_PER_100MS);
    assign exit_pulse = cmd_mode && (cmd_exit || idle_out);
    always_ff @(posedge aclk)
    begin
        if (!aresetn) begin cmd_mode <= 1'b0; idle_ms_reg <= '0; end
        else if (enter) begin cmd_mode <= 1'b1; idle_ms_reg <= '0; end
        else if (exit_pulse) cmd_mode <= 1'b0;
        else if (cmd_valid) idle_ms_reg <= '0;
        else if (tick_reg) idle_ms_reg <= idle_ms_reg + 32'h1;
    end

    // sleep sequencer
    cms_pkg::cms_pwr_t st_reg;
    logic [31:0] tmr_reg;
    logic [15:0] wh_reg;
    wire cyc = (sel == cms_pkg::SEL_CYCLIC) || (sel == cms_pkg::SEL_CYCLIC_PIN);
    wire pin = (sel == cms_pkg::SEL_PIN);
    wire refresh_ok = !opts[cms_pkg::OPT_NO_REFRESH_BIT] && rx_valid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn) begin st_reg <= cms_pkg::PWR_AWAKE; tmr_reg <= '0; end
        else
        begin
            unique case (st_reg)
                cms_pkg::PWR_AWAKE:
                begin
                    if (refresh_ok) tmr_reg <= '0;
                    else if (tick_reg) tmr_reg <= tmr_reg + 32'h1;
                    if (pin && pin_sleep_s) st_reg <= cms_pkg::PWR_SLEEP;
                    else if (cyc && tmr_reg >= wake_win)
                    begin
                        st_reg <= cms_pkg::PWR_ASSOC; tmr_reg <= '0;
                    end
                end
                cms_pkg::PWR_ASSOC:
                begin
                    if (tick_reg) tmr_reg <= tmr_reg + 32'h1;
                    if (assoc_s || tmr_reg >= assoc_to) st_reg <= cms_pkg::PWR_DRAIN;
                end
                cms_pkg::PWR_DRAIN:
                begin
                    tmr_reg <= '0;
                    if (!pend_s) st_reg <= cms_pkg::PWR_SLEEP;
                end
                cms_pkg::PWR_SLEEP:
                begin
                    if (tick_reg) tmr_reg <= tmr_reg + 32'h1;
                    if ((pin && !pin_sleep_s) || (sel == cms_pkg::SEL_CYCLIC_PIN && pin_sleep_s)
                        || (cyc && tmr_reg >= sleep_per * cms_pkg::TICKS_PER_10MS)
                        || (!pin && !cyc))
                    begin
                        st_reg <= cms_pkg::PWR_AWAKE; tmr_reg <= '0;
                    end
                end
            endcase
        end
    end

    // host-wake delay and drive outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wh_reg <= '0; asleep <= 1'b0; keep_assoc <= 1'b0; host_tx_allow <= 1'b1;
        end
        else
        begin
            asleep     <= (st_reg == cms_pkg::PWR_SLEEP);
            keep_assoc <= (st_reg == cms_pkg::PWR_SLEEP) && opts[cms_pkg::OPT_KEEP_ASSOC_BIT];
            if (st_reg == cms_pkg::PWR_SLEEP) wh_reg <= wh_ms;
            else if (rx_valid) wh_reg <= '0;
            else if (tick_reg && wh_reg != 16'h0) wh_reg <= wh_reg - 16'h1;
            host_tx_allow <= (st_reg != cms_pkg::PWR_SLEEP) && (wh_reg == 16'h0);
        end
    end

    // read path
    wire [15:0] cfg_code = a_reg[0][7:0] ^ {a_reg[2][7:0], a_reg[1][7:0]} ^ a_reg[5][15:0]
                           ^ {a_reg[3][7:0], a_reg[6][7:0]};
    logic [31:0] rd_val;
    logic        rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        rd_val = '0;
        unique case (s_axi_araddr)
            cms_pkg::OFS_CTRL:      rd_val = '0;
            cms_pkg::OFS_STATUS:    rd_val = {27'h0, st_reg == cms_pkg::PWR_SLEEP, cmd_mode,
                                              esc_n_reg, armed_reg};
            cms_pkg::OFS_LINK_MARG: rd_val = {24'h0, link_margin};
            cms_pkg::OFS_SUPPLY_MV: rd_val = {16'h0, supply_mv};
            cms_pkg::OFS_CFG_CODE:  rd_val = {16'h0, cfg_code};
            default:
                if (s_axi_araddr[7:6] == 2'b00 && s_axi_araddr[5:2] >= 4'd1
                    && s_axi_araddr[5:2] <= 4'd9 && s_axi_araddr[1:0] == 2'b00)
                    rd_val = q_reg[s_axi_araddr[5:2] - 4'd1];
                else rd_ok = 1'b0;
        endcase
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0; s_axi_rdata <= '0; s_axi_rresp <= 2'b00;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1; s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
            end
            else if (s_axi_rready) s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    property p_exit_applies;
        @(posedge aclk) disable iff (!aresetn)
        (cmd_mode && cmd_exit) |=> (!cmd_mode && a_reg[0] == $past(q_reg[0]));
    endproperty
    a_exit_applies: assert property (p_exit_applies) else $error("exit did not apply");
    property p_timeout;
        @(posedge aclk) disable iff (!aresetn)
        (cmd_mode && idle_out) |=> !cmd_mode;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout ignored");
    property p_abort;
        @(posedge aclk) disable iff (!aresetn)
        (rx_valid && !is_esc) |=> (esc_n_reg == 2'h0);
    endproperty
    a_abort: assert property (p_abort) else $error("escape not aborted");
    property p_entry_guard;
        @(posedge aclk) disable iff (!aresetn)
        $rose(cmd_mode) |-> $past(quiet_reg) >= $past(guard);
    endproperty
    a_entry_guard: assert property (p_entry_guard) else $error("entry without guard");
    property p_wh_stop;
        @(posedge aclk) disable iff (!aresetn)
        (rx_valid && st_reg != cms_pkg::PWR_SLEEP) |=> (wh_reg == 16'h0);
    endproperty
    a_wh_stop: assert property (p_wh_stop) else $error("wake delay not stopped");
    property p_drain;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg == cms_pkg::PWR_DRAIN && pend_s) |=> st_reg != cms_pkg::PWR_SLEEP;
    endproperty
    a_drain: assert property (p_drain) else $error("slept with pending data");
    property p_nosleep;
        @(posedge aclk) disable iff (!aresetn)
        (sel == cms_pkg::SEL_NONE && st_reg == cms_pkg::PWR_AWAKE) |=> st_reg == cms_pkg::PWR_AWAKE;
    endproperty
    a_nosleep: assert property (p_nosleep) else $error("slept in no-sleep mode");
    property p_queue;
        @(posedge aclk) disable iff (!aresetn)
        !(apply_pulse || exit_pulse) |=> $stable(a_reg[4]);
    endproperty
    a_queue: assert property (p_queue) else $error("active changed unapplied");
endmodule // cms_top
`default_nettype wire

/* tb/cms_host.sv */
// serial host model: hands characters to the block as one-cycle strobes
// assumes tasks are called right after a rising edge of aclk
`default_nettype none
module cms_host (
    // clock
    input  wire logic       aclk,
    // received character towards the block
    output var  logic       rx_valid,
    output var  logic [7:0] rx_char
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle line
    initial
    begin
        rx_valid = 1'b0;
        rx_char  = 8'h00;
    end

    // stale data shows the inverse, so an old value never passes as fresh
    task automatic send(input logic [7:0] c);
        rx_valid <= 1'b1;
        rx_char  <= c;
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_char  <= ~c;
        @(posedge aclk);
    endtask

    // silence, n escape characters, silence; n above 3 breaks it on purpose
    task automatic escape(input logic [7:0] c, input int n, input int quiet);
        repeat (quiet) @(posedge aclk);
        repeat (n) send(c);
        repeat (quiet) @(posedge aclk);
    endtask
endmodule // cms_host
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the command mode and sleep timing block
// assumes a 1 ms tick shortened to 4 cycles through TICK_CYCLES
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    localparam int C  = 0;
    localparam int S  = 1;
    localparam int K  = 2;
    localparam int H  = 3;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  awaddr;
    logic [7:0]  araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] got;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic        rx_valid;
    logic [7:0]  rx_char;
    logic        cmd_valid;
    logic        cmd_exit;
    logic        sleep_pin;
    logic        assoc_done;
    logic        xfer_pending;
    logic [7:0]  lm;
    logic [15:0] mv;
    logic [7:0]  esc;
    wire logic [3:0] outs;
    int          bad_count;
    int          compares;
    logic [31:0] rst [9] = '{cms_pkg::RST_CMD_TO, cms_pkg::RST_GUARD, cms_pkg::RST_ESC_CHAR,
        cms_pkg::RST_SLEEP_SEL, cms_pkg::RST_SLEEP_PER, cms_pkg::RST_SLEEP_OPT,
        cms_pkg::RST_HOST_WAKE, cms_pkg::RST_WAKE_WIN, cms_pkg::RST_ASSOC_TO};

    cms_top #(.TICK_CYCLES(TK)) cms_top_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_valid(rx_valid),
        .rx_char(rx_char), .cmd_valid(cmd_valid), .cmd_exit(cmd_exit),
        .sleep_pin(sleep_pin), .assoc_done(assoc_done), .xfer_pending(xfer_pending),
        .link_margin(lm), .supply_mv(mv), .cmd_mode(outs[C]), .asleep(outs[S]),
        .keep_assoc(outs[K]), .host_tx_allow(outs[H]));

    cms_host cms_host_i (.aclk(aclk), .rx_valid(rx_valid), .rx_char(rx_char));

    // 250 MHz
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic close_out();
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one write; address and data released each on its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        // let an edge pass so a following call never re-raises bready in this step
        @(posedge aclk);
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    // configuration code expected from the reset settings
    function automatic logic [31:0] cfg_exp();
        logic [15:0] h;
        h = 16'(rst[0][7:0]) ^ {rst[2][7:0], rst[1][7:0]} ^ rst[5][15:0]
            ^ {rst[3][7:0], rst[6][7:0]};
        return {16'h0, h};
    endfunction

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        got = rdata;
        rready <= 1'b0;
        // let an edge pass so a following call never re-raises rready in this step
        @(posedge aclk);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    // bounded wait for an output level
    task automatic wait_on(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (outs[k] !== v && n < lim)
        begin
            @(posedge aclk);
            n++;
        end
        chk({31'h0, outs[k]}, {31'h0, v});
    endtask

    task automatic hold(input int k, input logic v, input int cyc);
        int bad;
        bad = 0;
        repeat (cyc)
        begin
            @(posedge aclk);
            if (outs[k] !== v) bad = 1;
        end
        chk(bad, 0);
    endtask

    task automatic pulse_exit();
        cmd_exit <= 1'b1;
        @(posedge aclk);
        cmd_exit <= 1'b0;
        @(posedge aclk);
    endtask

    // the whole run stays far below this span
    initial
    begin
        repeat (40000) @(posedge aclk);
        bad_count++;
        close_out();
    end

    initial
    begin
        aresetn = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {cmd_valid, cmd_exit, sleep_pin, xfer_pending} = 4'h0;
        assoc_done = 1'b1;
        bad_count = 0;
        compares = 0;
        void'($urandom(32'hABB0B60A));
        lm = 8'($urandom);
        mv = 16'($urandom);
        esc = 8'($urandom);
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // defaults, read-only status and an unmapped place
        for (int i = 0; i < 9; i++)
        begin
            rd(8'h04 + 8'(4 * i), 2'b00);
            chk(got, rst[i]);
        end
        rd(cms_pkg::OFS_LINK_MARG, 2'b00);
        chk(got, {24'h0, lm});
        rd(cms_pkg::OFS_SUPPLY_MV, 2'b00);
        chk(got, {16'h0, mv});
        rd(cms_pkg::OFS_CFG_CODE, 2'b00);
        chk(got, cfg_exp());
        rd(8'h3C, 2'b10);
        wr(8'h3C, 32'h1, 2'b10);
        // short guard and timeout stay queued until applied
        wr(cms_pkg::OFS_GUARD, 32'h2, 2'b00);
        wr(cms_pkg::OFS_CMD_TO, 32'h2, 2'b00);
        wr(cms_pkg::OFS_ESC_CHAR, {24'h0, esc}, 2'b00);
        cms_host_i.escape(esc, 3, 3 * TK);
        hold(C, 1'b0, 20);
        wr(cms_pkg::OFS_CTRL, 32'h1, 2'b00);
        cms_host_i.escape(esc, 4, 3 * TK);
        hold(C, 1'b0, 10 * TK);
        cms_host_i.escape(esc, 3, 3 * TK);
        wait_on(C, 1'b1, 5 * TK);
        rd(cms_pkg::OFS_STATUS, 2'b00);
        chk(got, 32'h0000_0008);
        // exit command applies a queued escape character
        wr(cms_pkg::OFS_ESC_CHAR, {24'h0, ~esc}, 2'b00);
        pulse_exit();
        wait_on(C, 1'b0, 10);
        cms_host_i.escape(~esc, 3, 3 * TK);
        wait_on(C, 1'b1, 5 * TK);
        // a valid command restarts the 200 ms inactivity count
        hold(C, 1'b1, 400);
        cmd_valid <= 1'b1;
        @(posedge aclk);
        cmd_valid <= 1'b0;
        hold(C, 1'b1, 190 * TK);
        wait_on(C, 1'b0, 30 * TK);
        // cyclic sleep; unused option bits written as zero
        wr(cms_pkg::OFS_SLEEP_PER, 32'h1, 2'b00);
        wr(cms_pkg::OFS_WAKE_WIN, 32'h1, 2'b00);
        wr(cms_pkg::OFS_HOST_WAKE, 32'h4, 2'b00);
        wr(cms_pkg::OFS_SLEEP_OPT, 32'h140, 2'b00);
        wr(cms_pkg::OFS_SLEEP_SEL, 32'h4, 2'b00);
        wr(cms_pkg::OFS_CTRL, 32'h1, 2'b00);
        wait_on(S, 1'b1, 9000);
        wait_on(K, 1'b1, 4);
        xfer_pending <= 1'b1;
        hold(S, 1'b1, 7 * TK);
        wait_on(S, 1'b0, 6 * TK);
        chk({31'h0, outs[H]}, 32'h0);
        hold(S, 1'b0, 10 * TK);
        wait_on(H, 1'b1, 3 * TK);
        xfer_pending <= 1'b0;
        wait_on(S, 1'b1, 5 * TK);
        wait_on(S, 1'b0, 15 * TK);
        cms_host_i.send(8'h55);
        wait_on(H, 1'b1, 3);
        // pin sleep follows the pin; no sleep ignores it
        wr(cms_pkg::OFS_SLEEP_SEL, 32'h1, 2'b00);
        wr(cms_pkg::OFS_CTRL, 32'h1, 2'b00);
        sleep_pin <= 1'b1;
        wait_on(S, 1'b1, 100);
        sleep_pin <= 1'b0;
        wait_on(S, 1'b0, 100);
        wr(cms_pkg::OFS_SLEEP_SEL, 32'h0, 2'b00);
        wr(cms_pkg::OFS_CTRL, 32'h1, 2'b00);
        sleep_pin <= 1'b1;
        hold(S, 1'b0, 50);
        close_out();
    end
endmodule // tb
`default_nettype wire
